/* rtl/drsc_pkg.sv */
// Package: constants, types and register map of the reset/shutdown controller
package drsc_pkg;
	// ------------------------------------------------------------
	// Register map (word offsets as byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_GAIN = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MOD = 8'h0C;
	localparam logic [7:0] ADDR_DATA0 = 8'h10;
	localparam logic [7:0] ADDR_DATA1 = 8'h14;
	localparam logic [7:0] ADDR_PHASE = 8'h18;
	localparam logic [7:0] ADDR_ID = 8'h1C;
	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int CFG_SHDN_LSB = 0;
	localparam int CFG_SRST_LSB = 2;
	localparam int CFG_VREF_BIT = 4;
	localparam int CFG_CLK_BIT = 5;
	localparam int CFG_BSEN_LSB = 6;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [5:0] GAIN_RST = 6'h00;
	localparam logic [7:0] PHASE_RST = 8'h00;
	localparam logic [3:0] ZERO_PATTERN = 4'h3;
	localparam logic [3:0] RESET_PATTERN = 4'h3;
	localparam logic [31:0] ID_VALUE = 32'h0000D5C1; // Arbitrary value
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SAMPLE_DIV = 4;
	localparam int DR_OSR = 64;
	localparam int SETTLE_PERIODS = 3;
	localparam int STARTUP_PERIODS = 3;
	localparam logic [1:0] SHDN_ALL = 2'h3;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] bs_en;
		logic ext_clk;
		logic ext_ref;
		logic [1:0] soft_rst;
		logic [1:0] shdn;
	} drsc_cfg_t;
	typedef struct packed {
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic we;
		logic cyc;
		logic stb;
	} drsc_wb_req_t;
	typedef enum logic [0:0] {CH_IDLE, CH_RUN} drsc_ch_state_t;
endpackage : drsc_pkg

/* rtl/drsc_ctrl.sv */
// Reset and shutdown sequencer for a dual delta-sigma converter front end
//
// How it works
// - Reset pin or power-on resets every register
// - Bitstream pins float during hard reset
// - Hard reset forces 0011, clears data, filters
// - Serial interface held in reset, no transactions
// - Leaving shutdown: first ready after filter settling
// - Channels shut down independently, config kept
// - Shut channel: data zero, no ready pulses
// - One shut channel: bitstream repeats 0011 when enabled
// - Returning channel realigns phase to running one
// - Both shut: gate core clock; restore on resume
// - Shutdown 11 plus ext ref/clk: full shutdown
// - Register interface stays alive in full shutdown
// - Any bit back to 0 restarts supply monitors
// - Exit full shutdown: full reset, ready after three
// - Gain code 000..101 decodes to 1..32
// - Gain codes 110 and 111 mean one
// - Quantizer: four comparators, thermometer, four levels
// - Modulator output refreshed once per sampling period
// - Modulator output in register and serial pin
// - Soft reset: running, output zero, no ready
`timescale 1ns/1ps
module drsc_ctrl
	import drsc_pkg::*;
#(
	parameter int SAMPLE_DIV_P = SAMPLE_DIV,
	parameter int OSR_P = DR_OSR
)(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic por_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] comp_level0_i,
	input wire logic [1:0] comp_level1_i,
	output logic [1:0] data_ready_o,
	output logic [1:0] modulator_bitstream_out_o,
	output logic [1:0] modulator_bitstream_oe_o,
	output logic [1:0] bias_en_o,
	output logic input_clk_en_o,
	output logic core_clk_en_o,
	output logic supply_mon_en_o,
	output logic int_ref_en_o,
	output logic [5:0] gain0_o,
	output logic [5:0] gain1_o
);
	import drsc_pkg::*;

	// ------------------------------------------------------------
	// Reset synchronisation and power-on reset
	// ------------------------------------------------------------
	logic por_s1_r;
	logic por_s2_r;
	logic hard_rst;
	logic full_sd;
	logic full_sd_d_r;
	logic full_exit;
	logic soft_por;

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			por_s1_r <= 1'b1;
			por_s2_r <= 1'b1;
		end
		else
		begin
			por_s1_r <= por_i;
			por_s2_r <= por_s1_r;
		end
	end

	// Power-on reset only counts while the monitors are enabled
	assign hard_rst = por_s2_r & supply_mon_en_o;
	assign full_exit = full_sd_d_r & ~full_sd;
	assign soft_por = hard_rst | full_exit;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	drsc_cfg_t cfg_r;
	logic [5:0] gain_r;
	logic [7:0] phase_r;
	logic [23:0] data_r [2];
	logic [7:0] mod_r;
	logic wr_en;
	logic rd_en;

	// Bus is refused during hard reset; no ack is given
	assign rd_en = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~hard_rst;
	assign wr_en = rd_en & wb_we_i & wb_sel_i[0];

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= rd_en;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cfg_r <= CONFIG_RST;
			gain_r <= GAIN_RST;
			phase_r <= PHASE_RST;
		end
		else if (soft_por)
		begin
			cfg_r <= CONFIG_RST;
			gain_r <= GAIN_RST;
			phase_r <= PHASE_RST;
		end
		else if (wr_en)
		begin
			unique case (wb_adr_i)
				ADDR_CONFIG: cfg_r <= wb_dat_i[7:0];
				ADDR_GAIN: gain_r <= wb_dat_i[5:0];
				ADDR_PHASE: phase_r <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			wb_dat_o <= 32'h00000000;
		else if (rd_en)
		begin
			unique case (wb_adr_i)
				ADDR_CONFIG: wb_dat_o <= {24'h000000, cfg_r};
				ADDR_GAIN: wb_dat_o <= {26'h0000000, gain_r};
				ADDR_STATUS: wb_dat_o <= {26'h0000000, full_sd, core_clk_en_o,
					data_ready_o, bias_en_o};
				ADDR_MOD: wb_dat_o <= {24'h000000, mod_r};
				ADDR_DATA0: wb_dat_o <= {8'h00, data_r[0]};
				ADDR_DATA1: wb_dat_o <= {8'h00, data_r[1]};
				ADDR_PHASE: wb_dat_o <= {24'h000000, phase_r};
				ADDR_ID: wb_dat_o <= ID_VALUE;
				default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Power state decode
	// ------------------------------------------------------------
	assign full_sd = (cfg_r.shdn == SHDN_ALL) & cfg_r.ext_ref & cfg_r.ext_clk;

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			full_sd_d_r <= 1'b0;
		else
			full_sd_d_r <= full_sd;
	end

	// Monitors come back as soon as any of the bits drops
	assign supply_mon_en_o = ~full_sd;
	assign int_ref_en_o = ~full_sd & ~cfg_r.ext_ref;
	assign core_clk_en_o = (cfg_r.shdn != SHDN_ALL) & ~hard_rst;
	assign input_clk_en_o = cfg_r.shdn != SHDN_ALL;
	assign bias_en_o = ~cfg_r.shdn;

	// ------------------------------------------------------------
	// Gain decode
	// ------------------------------------------------------------
	function automatic logic [5:0] gain_decode(input logic [2:0] code);
		logic [5:0] g;
		g = 6'h01;
		if (code <= 3'h5)
			g = 6'(6'h01 << code);
		else
			g = 6'h01;
		return g;
	endfunction : gain_decode

	assign gain0_o = gain_decode(gain_r[2:0]);
	assign gain1_o = gain_decode(gain_r[5:3]);

	// ------------------------------------------------------------
	// Sampling and data-rate timebase
	// ------------------------------------------------------------
	logic [7:0] samp_cnt_r;
	logic samp_tick;
	logic [15:0] dr_cnt_r;
	logic dr_tick;

	assign samp_tick = core_clk_en_o && (samp_cnt_r == 8'(SAMPLE_DIV_P - 1));
	assign dr_tick = samp_tick && (dr_cnt_r == 16'(OSR_P - 1));

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			samp_cnt_r <= 8'h00;
		else if (soft_por || !core_clk_en_o)
			samp_cnt_r <= 8'h00;
		else if (samp_tick)
			samp_cnt_r <= 8'h00;
		else
			samp_cnt_r <= samp_cnt_r + 8'h01;
	end

	// Data-rate phase persists across single-channel shutdown
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			dr_cnt_r <= 16'h0000;
		else if (soft_por)
			dr_cnt_r <= 16'h0000;
		else if (dr_tick)
			dr_cnt_r <= 16'h0000;
		else if (samp_tick)
			dr_cnt_r <= dr_cnt_r + 16'h0001;
	end

	// ------------------------------------------------------------
	// Per-channel quantizer, data and ready logic
	// ------------------------------------------------------------
	logic [1:0] pat_idx_r;
	logic [1:0] lvl [2];
	assign lvl[0] = comp_level0_i;
	assign lvl[1] = comp_level1_i;

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			pat_idx_r <= 2'h0;
		else if (soft_por)
			pat_idx_r <= 2'h0;
		else if (samp_tick)
			pat_idx_r <= pat_idx_r + 2'h1;
	end

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_ch
		logic [3:0] therm;
		logic [3:0] mod_q_r;
		logic [1:0] settle_r;
		logic first_r;
		logic idle;
		drsc_ch_state_t st_r;

		assign idle = cfg_r.shdn[ch] | cfg_r.soft_rst[ch];
		// Four comparators, thermometer coded: four levels 0000, 0001, 0011, 1111
		always_comb
		begin
			therm = 4'h0;
			for (int k = 0; k < 4; k++)
				therm[k] = (3'(lvl[ch]) + 3'(k >= 3)) > 3'(k);
		end

		always_ff @(posedge ref_clk_i or negedge resetn_i)
		begin
			if (!resetn_i)
				mod_q_r <= RESET_PATTERN;
			else if (soft_por)
				mod_q_r <= RESET_PATTERN;
			else if (samp_tick)
				mod_q_r <= idle ? ZERO_PATTERN : therm;
		end

		always_ff @(posedge ref_clk_i or negedge resetn_i)
		begin
			if (!resetn_i)
			begin
				st_r <= CH_IDLE;
				settle_r <= 2'h0;
				first_r <= 1'b1;
			end
			else if (soft_por)
			begin
				st_r <= CH_IDLE;
				settle_r <= 2'h0;
				first_r <= 1'b1;
			end
			else
			begin
				unique case (st_r)
					CH_IDLE:
						if (!idle)
						begin
							st_r <= CH_RUN;
							settle_r <= 2'h0;
						end
					CH_RUN:
						if (idle)
						begin
							st_r <= CH_IDLE;
							first_r <= 1'b1;
						end
						else if (dr_tick && settle_r != 2'(SETTLE_PERIODS - 1))
							settle_r <= settle_r + 2'h1;
						else if (dr_tick)
							first_r <= 1'b0;
				endcase
			end
		end

		// Ready follows the shared data-rate tick, realigning to the other channel
		always_ff @(posedge ref_clk_i or negedge resetn_i)
		begin
			if (!resetn_i)
				data_ready_o[ch] <= 1'b0;
			else
				data_ready_o[ch] <= ~soft_por & dr_tick & ~idle & (st_r == CH_RUN)
					& (~first_r | settle_r == 2'(STARTUP_PERIODS - 1));
		end

		always_ff @(posedge ref_clk_i or negedge resetn_i)
		begin
			if (!resetn_i)
				data_r[ch] <= 24'h000000;
			else if (soft_por || idle)
				data_r[ch] <= 24'h000000;
			else if (dr_tick && st_r == CH_RUN)
				data_r[ch] <= {12'h000, 4'(therm), phase_r};
		end

		always_ff @(posedge ref_clk_i or negedge resetn_i)
		begin
			if (!resetn_i)
				modulator_bitstream_out_o[ch] <= 1'b0;
			else
				modulator_bitstream_out_o[ch] <= mod_q_r[pat_idx_r];
		end

		// Bitstream pin floats in hard reset
		assign modulator_bitstream_oe_o[ch] = cfg_r.bs_en[ch] & ~hard_rst;
	end

	assign mod_r = {g_ch[1].mod_q_r, g_ch[0].mod_q_r};
endmodule : drsc_ctrl

/* verification/drsc_ctrl_sva.sv */
// Port assertions of the reset and shutdown sequencer
`timescale 1ns/1ps
module drsc_ctrl_chk #(
	parameter int SAMPLE_DIV_P = 4,
	parameter int OSR_P = 64
)(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic por_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [1:0] data_ready_o,
	input wire logic [1:0] modulator_bitstream_oe_o,
	input wire logic [1:0] bias_en_o,
	input wire logic input_clk_en_o,
	input wire logic core_clk_en_o,
	input wire logic supply_mon_en_o,
	input wire logic [5:0] gain0_o,
	input wire logic [5:0] gain1_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);
	// Cycles since reset release or power-on request, saturating at three
	logic [1:0] calm_r;
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			calm_r <= 2'h0;
		else if (por_i)
			calm_r <= 2'h0;
		else if (calm_r != 2'h3)
			calm_r <= calm_r + 2'h1;
	end
	property p_rst_idle;
		$rose(resetn_i) |-> !wb_ack_o && modulator_bitstream_oe_o == 2'h0 && data_ready_o == 2'h0;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("active after reset");
	property p_bus_hold;
		$rose(resetn_i) |-> !wb_ack_o [*3];
	endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("bus answered in reset");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_quiet0;
		!bias_en_o[0] [*2] |-> !data_ready_o[0];
	endproperty
	a_quiet0: assert property (p_quiet0) else $error("ready from shut ch0");
	property p_quiet1;
		!bias_en_o[1] [*2] |-> !data_ready_o[1];
	endproperty
	a_quiet1: assert property (p_quiet1) else $error("ready from shut ch1");
	property p_settle;
		$rose(bias_en_o[0]) |-> !data_ready_o[0] [*8];
	endproperty
	a_settle: assert property (p_settle) else $error("ready before settling");
	property p_gate;
		bias_en_o == 2'h0 [*2] |-> !core_clk_en_o && !input_clk_en_o;
	endproperty
	a_gate: assert property (p_gate) else $error("clock not gated");
	// Hard reset from a power-on request gates the core clock on purpose
	property p_run;
		bias_en_o != 2'h0 && calm_r == 2'h3 |-> core_clk_en_o && supply_mon_en_o;
	endproperty
	a_run: assert property (p_run) else $error("clock or monitor off");
	property p_gain;
		$onehot(gain0_o) && $onehot(gain1_o);
	endproperty
	a_gain: assert property (p_gain) else $error("gain not a power of two");
endmodule : drsc_ctrl_chk
bind drsc_ctrl drsc_ctrl_chk #(.SAMPLE_DIV_P(SAMPLE_DIV_P), .OSR_P(OSR_P)) u_chk (
	.ref_clk_i(ref_clk_i),
	.resetn_i(resetn_i),
	.por_i(por_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.data_ready_o(data_ready_o),
	.modulator_bitstream_oe_o(modulator_bitstream_oe_o),
	.bias_en_o(bias_en_o),
	.input_clk_en_o(input_clk_en_o),
	.core_clk_en_o(core_clk_en_o),
	.supply_mon_en_o(supply_mon_en_o),
	.gain0_o(gain0_o),
	.gain1_o(gain1_o)
);

/* verification/drsc_host_model.sv */
// Host stand-in: classic Wishbone master
`timescale 1ns/1ps
module drsc_host_model (
	input wire logic clk_i,
	input wire logic ack_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [31:0] dat_o,
	output logic [3:0] sel_o
);
	assign sel_o = 4'hF;
	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		dat_o = 32'h0;
	end
	// Never called in hard reset; results right after a resume unused
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output bit ok);
		int n;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		dat_o <= d;
		ok = 1'b0;
		for (n = 0; n < 20 && !ok; n++)
		begin
			@(posedge clk_i);
			ok = ack_i;
		end
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
	endtask : xfer
endmodule : drsc_host_model

/* verification/tb_dual_adc_reset_shutdown_ctrl.sv */
// Self-checking bench of the reset and shutdown sequencer
`timescale 1ns/1ps
module tb_dual_adc_reset_shutdown_ctrl;
	import drsc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic por_i = 1'b0;
	logic [1:0] cl0 = 2'h0, cl1 = 2'h0, rdy, bs, oe, bias;
	logic cyc, stb, we, ack, ice, cce, sme, ire;
	logic [7:0] adr;
	logic [31:0] wdat, rdat;
	logic [3:0] sel;
	logic [5:0] g0, g1;
	logic [31:0] exp_q[$];
	int mismatches = 0;
	int samples_checked = 0;
	int n0 = 0;
	int n1 = 0;
	always #2 ref_clk_i = ~ref_clk_i;
	drsc_ctrl #(.SAMPLE_DIV_P(2), .OSR_P(4)) u_dut (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .por_i(por_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.comp_level0_i(cl0), .comp_level1_i(cl1), .data_ready_o(rdy),
		.modulator_bitstream_out_o(bs), .modulator_bitstream_oe_o(oe),
		.bias_en_o(bias), .input_clk_en_o(ice), .core_clk_en_o(cce),
		.supply_mon_en_o(sme), .int_ref_en_o(ire), .gain0_o(g0), .gain1_o(g1)
	);
	drsc_host_model u_host (
		.clk_i(ref_clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .dat_o(wdat), .sel_o(sel)
	);
	function automatic logic [5:0] gexp(input int c);
		return (c < 6) ? 6'h01 << c : 6'h01;
	endfunction : gexp
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic report_and_stop(input int extra);
		mismatches += extra + exp_q.size();
		$display("compares %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		bit ok;
		u_host.xfer(w, a, d, ok);
		if (!ok)
			report_and_stop(1);
		@(negedge ref_clk_i);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	always @(posedge ref_clk_i)
	begin
		cl0 <= 2'($urandom);
		cl1 <= 2'($urandom);
		n0 <= n0 + int'(rdy[0] === 1'b1);
		n1 <= n1 + int'(rdy[1] === 1'b1);
	end
	// Read data is judged at the acknowledging edge
	always @(posedge ref_clk_i)
		if (ack === 1'b1 && we === 1'b0)
			cmp(rdat, exp_q.size() > 0 ? exp_q.pop_front() : 32'hX);
	initial
	begin
		int c0;
		int c1;
		logic [7:0] cfg;
		void'($urandom(49093));
		repeat (6) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		rd(ADDR_CONFIG, 32'(CONFIG_RST));
		rd(ADDR_ID, ID_VALUE);
		rd(8'h20, 32'h0);
		cmp({bias, ice, cce, sme, ire}, 32'h3F);
		for (int i = 0; i < 8; i++)
		begin
			c1 = $urandom_range(7, 0);
			bus(1'b1, ADDR_GAIN, 32'(i + 8 * c1));
			cmp({g1, g0}, {gexp(c1), gexp(i)});
		end
		// Shut or soft-reset one channel at a time
		for (int k = 0; k < 4; k++)
		begin
			cfg = 8'h01 << k;
			bus(1'b1, ADDR_CONFIG, 32'(cfg));
			repeat (4) @(posedge ref_clk_i);
			c0 = n0;
			c1 = n1;
			repeat (100) @(posedge ref_clk_i);
			@(negedge ref_clk_i);
			cmp({n0 == c0, n1 == c1}, {k[0] == 0, k[0] == 1});
			cmp(bias, (k < 2) ? 2'(~cfg[1:0]) : 2'h3);
			rd(ADDR_CONFIG, 32'(cfg));
			rd(k[0] ? ADDR_DATA1 : ADDR_DATA0, 32'h0);
		end
		bus(1'b1, ADDR_GAIN, 32'h09);
		bus(1'b1, ADDR_CONFIG, 32'h03);
		cmp({ice, cce, sme}, 32'h1);
		bus(1'b1, ADDR_CONFIG, 32'h33);
		cmp({sme, ire, cce}, 32'h0);
		rd(ADDR_CONFIG, 32'h33);
		bus(1'b1, ADDR_CONFIG, 32'h13);
		cmp(sme, 32'h1);
		rd(ADDR_CONFIG, 32'h0);
		rd(ADDR_GAIN, 32'h0);
		// Ch0 shut, ch1 in soft reset, both bitstream pins enabled
		bus(1'b1, ADDR_CONFIG, 32'hC9);
		repeat (8) @(posedge ref_clk_i);
		c0 = 0;
		c1 = 0;
		// A repeated 0011 stream is ones half of the time
		repeat (16)
		begin
			@(posedge ref_clk_i);
			c0 += int'(bs[0] === 1'b1);
			c1 += int'(bs[1] === 1'b1);
		end
		cmp({16'(c1), 16'(c0)}, 32'h00080008);
		cmp(oe, 32'h3);
		rd(ADDR_MOD, 32'h33);
		@(posedge ref_clk_i);
		por_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		cmp(oe, 32'h0);
		repeat (2) @(posedge ref_clk_i);
		por_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		rd(ADDR_CONFIG, 32'h0);
		report_and_stop(0);
	end
endmodule : tb_dual_adc_reset_shutdown_ctrl
